// ==== rtl/esc_cfg.svh ====
`ifndef ESC_CFG_SVH
`define ESC_CFG_SVH
`define ESC_NUM_CS 4
`define ESC_CS_W 2
`define ESC_BOOT_SINGLE_LVL 1'h0
`define ESC_ENDIAN_BIG_LVL 1'h1
`define ESC_TYPE_CPU 1'h0
`define ESC_TYPE_REVERSED 1'h1
`define ESC_DMA_LITTLE 1'h0
`define ESC_DMA_BIG 1'h1
`define ESC_ADDR_LANE_MASK 2'h3
`define ESC_SIZE_BYTE 2'h0
`define ESC_SIZE_HALF 2'h1
`define ESC_SIZE_WORD 2'h2
`define ESC_HALF_LANE_MASK 2'h2
`endif

// ==== rtl/esc_endian_select_and_convert.sv ====
`timescale 1ns/100ps
`include "esc_cfg.svh"
// Function
// [RULE1] byte order from boot mode and pin
// [RULE2] boot pin low at release: single boot
// [RULE3] single boot is always little-endian
// [RULE4] order pin low little, high big
// [RULE5] per chip select order type bit
// [RULE6] dma order bit: 0 little, 1 big
// [RULE7] software matches dma bit to pin order
// [RULE8] dma treated like cpu operand access
// [RULE9] converters on peripheral and dma paths
// [RULE10] little mode converts only reversed external
// [RULE11] big mode internal memory not converted
// [RULE12] big mode peripheral registers byte-reversed
// [RULE13] big mode dma data byte-reversed
// [RULE14] big mode reversed external areas converted
// [RULE15] reversed format matches register alignment
// [RULE16] swap lanes 0/3, 1/2, remap addresses
// [RULE17] capture pins at reset release, hold
module esc_endian_select_and_convert (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic boot_mode_pin,
    input wire logic byte_order_pin,
    input wire logic [`ESC_NUM_CS-1:0] chip_select_area_config,
    input wire logic dma_channel_config,
    // peripheral bridge path
    input wire logic per_valid,
    input wire logic per_is_external,
    input wire logic [`ESC_CS_W-1:0] per_cs,
    input wire logic [1:0] per_size,
    input wire logic [1:0] per_addr_lo,
    input wire logic [31:0] per_wdata_in,
    input wire logic [31:0] per_rdata_in,
    output logic per_convert,
    output logic [1:0] per_addr_lo_out,
    output logic [31:0] per_wdata_out,
    output logic [31:0] per_rdata_out,
    // dma path
    input wire logic dma_valid,
    input wire logic dma_is_external,
    input wire logic dma_is_periph,
    input wire logic [`ESC_CS_W-1:0] dma_cs,
    input wire logic [1:0] dma_size,
    input wire logic [1:0] dma_addr_lo,
    input wire logic [31:0] dma_wdata_in,
    input wire logic [31:0] dma_rdata_in,
    output logic dma_convert,
    output logic [1:0] dma_addr_lo_out,
    output logic [31:0] dma_wdata_out,
    output logic [31:0] dma_rdata_out,
    // status
    output logic big_endian,
    output logic single_boot,
    output logic dma_order_mismatch
);
    logic rst_d_ff;
    logic big_ff;
    logic boot_ff;
    logic release_pulse;
    logic nxt_big;
    logic nxt_boot;
    logic per_cs_rev;
    logic dma_cs_rev;
    logic per_conv_w;
    logic dma_conv_w;
    logic [31:0] per_wdata_sw;
    logic [31:0] per_rdata_sw;
    logic [31:0] dma_wdata_sw;
    logic [31:0] dma_rdata_sw;
    logic [1:0] per_addr_w;
    logic [1:0] dma_addr_w;
    esc_pkg::esc_format_t per_fmt;

    // pins sampled in the first cycle after reset drops, then frozen
    assign release_pulse = rst_d_ff & ~rst; // [RULE17]
    assign nxt_boot = (boot_mode_pin == `ESC_BOOT_SINGLE_LVL); // [RULE2]
    // single boot forces little-endian regardless of the order pin
    assign nxt_big = ~nxt_boot &
        (byte_order_pin == `ESC_ENDIAN_BIG_LVL); // [RULE1] [RULE3] [RULE4]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rst_d_ff <= 1'h1;
            big_ff <= 1'h0;
            boot_ff <= 1'h0;
        end else begin
            rst_d_ff <= 1'h0;
            if (release_pulse) begin // [RULE17]
                big_ff <= nxt_big;
                boot_ff <= nxt_boot;
            end
        end
    end

    assign big_endian = big_ff;
    assign single_boot = boot_ff;

    // byte swap function of a word; reversed format then equals register alignment
    function automatic logic [31:0] esc_swap(input logic [31:0] d);
        esc_swap = {d[7:0], d[15:8], d[23:16], d[31:24]}; // [RULE16] [RULE15]
    endfunction

    // narrow accesses: byte address flips all lane bits, half flips the upper bit
    function automatic logic [1:0] esc_remap(input logic [1:0] a, input logic [1:0] sz);
        esc_remap = (sz == `ESC_SIZE_BYTE) ? (a ^ `ESC_ADDR_LANE_MASK) :
                    (sz == `ESC_SIZE_HALF) ? (a ^ `ESC_HALF_LANE_MASK) : a; // [RULE16]
    endfunction

    assign per_cs_rev = chip_select_area_config[per_cs] == `ESC_TYPE_REVERSED; // [RULE5]
    assign dma_cs_rev = chip_select_area_config[dma_cs] == `ESC_TYPE_REVERSED; // [RULE5]

    // cpu path: internal memory never converted; peripheral regs only in big mode
    assign per_conv_w = per_valid &
        (per_is_external ? per_cs_rev : big_ff); // [RULE10] [RULE11] [RULE12] [RULE14]
    // dma follows the same treatment as a cpu operand access
    assign dma_conv_w = dma_valid & (dma_is_external ? dma_cs_rev :
                        (dma_is_periph & big_ff)); // [RULE8] [RULE13]

    assign per_fmt = ~per_is_external ? (big_ff ? esc_pkg::ESC_REVERSED_BIG : esc_pkg::ESC_LITTLE)
                   : per_cs_rev ? esc_pkg::ESC_REVERSED_BIG
                   : (big_ff ? esc_pkg::ESC_WORD_INV_BIG : esc_pkg::ESC_LITTLE);

    assign per_wdata_sw = esc_swap(per_wdata_in); // [RULE9]
    assign per_rdata_sw = esc_swap(per_rdata_in); // [RULE9]
    assign dma_wdata_sw = esc_swap(dma_wdata_in); // [RULE9]
    assign dma_rdata_sw = esc_swap(dma_rdata_in); // [RULE9]
    assign per_addr_w = per_conv_w ? esc_remap(per_addr_lo, per_size) : per_addr_lo;
    assign dma_addr_w = dma_conv_w ? esc_remap(dma_addr_lo, dma_size) : dma_addr_lo;

    // one register stage per path; costs a cycle but gives clean data outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            per_convert <= 1'h0;
            per_addr_lo_out <= 2'h0;
            per_wdata_out <= 32'h0;
            per_rdata_out <= 32'h0;
            dma_convert <= 1'h0;
            dma_addr_lo_out <= 2'h0;
            dma_wdata_out <= 32'h0;
            dma_rdata_out <= 32'h0;
            dma_order_mismatch <= 1'h0;
        end else begin
            per_convert <= per_conv_w;
            per_addr_lo_out <= per_addr_w;
            per_wdata_out <= per_conv_w ? per_wdata_sw : per_wdata_in;
            per_rdata_out <= per_conv_w ? per_rdata_sw : per_rdata_in;
            dma_convert <= dma_conv_w;
            dma_addr_lo_out <= dma_addr_w;
            dma_wdata_out <= dma_conv_w ? dma_wdata_sw : dma_wdata_in;
            dma_rdata_out <= dma_conv_w ? dma_rdata_sw : dma_rdata_in;
            // software must keep the dma order bit equal to the device order
            dma_order_mismatch <= dma_channel_config !=
                (big_ff ? `ESC_DMA_BIG : `ESC_DMA_LITTLE); // [RULE6] [RULE7]
        end
    end

    chk_boot_forces_little: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
        boot_ff |-> !big_ff) else $error("single boot not little-endian");
    chk_order_held: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
        !release_pulse |=> $stable(big_ff) && $stable(boot_ff))
        else $error("order changed after release");
    chk_capture_pins: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
        release_pulse |=> big_ff == $past(nxt_big) && boot_ff == $past(nxt_boot))
        else $error("pins not captured");
    chk_boot_level: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
        release_pulse && !boot_mode_pin |=> boot_ff) else $error("boot level wrong");
    chk_order_level: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
        release_pulse && boot_mode_pin |=> big_ff == $past(byte_order_pin))
        else $error("order pin level wrong");
    chk_ext_cs_type: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        per_valid && per_is_external |=> per_convert == $past(per_cs_rev))
        else $error("external conversion wrong");
    chk_periph_big: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
        per_valid && !per_is_external |=> per_convert == $past(big_ff))
        else $error("peripheral conversion wrong");
    chk_swap_lanes: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        per_conv_w |=> per_wdata_out[7:0] == $past(per_wdata_in[31:24]) &&
        per_wdata_out[15:8] == $past(per_wdata_in[23:16]))
        else $error("lane swap wrong");
    chk_dma_periph: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
        dma_valid && dma_is_periph && !dma_is_external |=> dma_convert == $past(big_ff))
        else $error("dma conversion wrong");
    chk_dma_mismatch: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
        ##1 dma_order_mismatch == ($past(dma_channel_config) != $past(big_ff)))
        else $error("dma mismatch flag wrong");

    // the rst term keeps the release edge out: outputs there still carry reset values
    chk_fmt_reversed: assert property (@(posedge core_clk) disable iff (rst) // [RULE15]
        per_valid |-> per_conv_w == (per_fmt == esc_pkg::ESC_REVERSED_BIG))
        else $error("format and conversion disagree");
    chk_fmt_cpu_order: assert property (@(posedge core_clk) disable iff (rst) // [RULE5]
        per_valid && per_is_external && chip_select_area_config[per_cs] == `ESC_TYPE_CPU |->
        per_fmt == (big_ff ? esc_pkg::ESC_WORD_INV_BIG : esc_pkg::ESC_LITTLE))
        else $error("external format wrong");
    chk_dma_ext_type: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
        !rst && dma_valid && dma_is_external |=> dma_convert == $past(dma_cs_rev))
        else $error("dma external conversion wrong");
    chk_dma_memory: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
        !rst && dma_valid && !dma_is_external && !dma_is_periph |=> !dma_convert)
        else $error("dma memory access converted");
    chk_idle_cpu: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
        !rst && !per_valid |=> !per_convert) else $error("idle cpu path converts");
    chk_idle_dma: assert property (@(posedge core_clk) disable iff (rst) // [RULE10]
        !rst && !dma_valid |=> !dma_convert) else $error("idle dma path converts");
    chk_pass_through: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
        !rst && !per_conv_w |=> per_wdata_out == $past(per_wdata_in) &&
        per_rdata_out == $past(per_rdata_in))
        else $error("unconverted data altered");
    chk_swap_upper: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        !rst && per_conv_w |=> per_wdata_out[31:24] == $past(per_wdata_in[7:0]) &&
        per_wdata_out[23:16] == $past(per_wdata_in[15:8]))
        else $error("upper lane swap wrong");
    chk_dma_swap: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
        !rst && dma_conv_w |=> dma_rdata_out[7:0] == $past(dma_rdata_in[31:24]) &&
        dma_rdata_out[31:24] == $past(dma_rdata_in[7:0]) &&
        dma_wdata_out[15:8] == $past(dma_wdata_in[23:16]))
        else $error("dma lane swap wrong");
    chk_addr_byte: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        !rst && per_conv_w && per_size == `ESC_SIZE_BYTE |=> per_addr_lo_out == ~$past(per_addr_lo))
        else $error("byte address remap wrong");
    chk_dma_addr_byte: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        !rst && dma_conv_w && dma_size == `ESC_SIZE_BYTE |=> dma_addr_lo_out == ~$past(dma_addr_lo))
        else $error("dma byte address remap wrong");
    chk_addr_half: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        !rst && per_conv_w && per_size == `ESC_SIZE_HALF |=>
        per_addr_lo_out[1] != $past(per_addr_lo[1]) && per_addr_lo_out[0] == $past(per_addr_lo[0]))
        else $error("half address remap wrong");
    chk_addr_word: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
        !rst && per_size == `ESC_SIZE_WORD |=> per_addr_lo_out == $past(per_addr_lo))
        else $error("word address changed");
endmodule

// ==== rtl/esc_pkg.sv ====
package esc_pkg;
    typedef enum logic [1:0] {
        ESC_LITTLE,
        ESC_WORD_INV_BIG,
        ESC_REVERSED_BIG
    } esc_format_t;
    typedef enum logic {
        ESC_SINGLE_CHIP,
        ESC_SINGLE_BOOT
    } esc_mode_t;
endpackage

// ==== testbench/esc_master.sv ====
`timescale 1ns/100ps
module esc_master (
    input wire logic core_clk,
    output logic valid,
    output logic ext,
    output logic periph,
    output logic [1:0] cs,
    output logic [1:0] size,
    output logic [1:0] addr,
    output logic [31:0] wdata,
    output logic [31:0] rdata
);
    initial {valid, ext, periph, cs, size, addr, wdata, rdata} = '0;
    // requests move only just after an edge, so each access is seen whole
    task automatic put(input logic v, e, p, input logic [1:0] c, s, a, input logic [31:0] d);
        @(posedge core_clk);
        {valid, ext, periph, cs, size, addr} <= {v, e, p, c, s, a};
        wdata <= d;
        rdata <= ~d;
    endtask
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    logic core_clk = 1'h0, rst = 1'h1, boot_mode_pin = 1'h1, byte_order_pin = 1'h0;
    logic [3:0] chip_select_area_config = 4'h2;
    logic dma_channel_config = 1'h0;
    logic per_valid, per_is_external, per_convert, dma_valid, dma_is_external, dma_is_periph;
    logic dma_convert, big_endian, single_boot, dma_order_mismatch;
    logic [1:0] per_cs, per_size, per_addr_lo, per_addr_lo_out;
    logic [1:0] dma_cs, dma_size, dma_addr_lo, dma_addr_lo_out;
    logic [31:0] per_wdata_in, per_rdata_in, per_wdata_out, per_rdata_out;
    logic [31:0] dma_wdata_in, dma_rdata_in, dma_wdata_out, dma_rdata_out;
    int failures = 0, comparisons = 0;
    always #2 core_clk = ~core_clk;
    esc_endian_select_and_convert i_dut (.core_clk, .rst, .boot_mode_pin, .byte_order_pin,
        .chip_select_area_config, .dma_channel_config, .per_valid, .per_is_external, .per_cs,
        .per_size, .per_addr_lo, .per_wdata_in, .per_rdata_in, .per_convert, .per_addr_lo_out,
        .per_wdata_out, .per_rdata_out, .dma_valid, .dma_is_external, .dma_is_periph, .dma_cs,
        .dma_size, .dma_addr_lo, .dma_wdata_in, .dma_rdata_in, .dma_convert, .dma_addr_lo_out,
        .dma_wdata_out, .dma_rdata_out, .big_endian, .single_boot, .dma_order_mismatch);
    esc_master i_cpu (.core_clk, .valid(per_valid), .ext(per_is_external), .periph(),
        .cs(per_cs), .size(per_size), .addr(per_addr_lo), .wdata(per_wdata_in),
        .rdata(per_rdata_in));
    esc_master i_dma (.core_clk, .valid(dma_valid), .ext(dma_is_external),
        .periph(dma_is_periph), .cs(dma_cs), .size(dma_size), .addr(dma_addr_lo),
        .wdata(dma_wdata_in), .rdata(dma_rdata_in));
    task automatic check(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // pins are flipped right after release so a design that keeps sampling shows up
    task automatic start(input logic b, o, eb, es);
        @(posedge core_clk);
        {rst, boot_mode_pin, byte_order_pin} <= {1'h1, b, o};
        repeat (12) @(posedge core_clk);
        {rst, dma_channel_config} <= {1'h0, eb};
        @(posedge core_clk);
        {boot_mode_pin, byte_order_pin} <= {~b, ~o};
        repeat (3) @(posedge core_clk);
        #1;
        check(32'(big_endian), 32'(eb));
        check(32'(single_boot), 32'(es));
        check(32'(dma_order_mismatch), 32'h0);
    endtask
    task automatic acc(input logic d, e, p, input logic [1:0] c, s, a, input logic cv);
        logic [1:0] ea;
        logic [31:0] w;
        ea = cv ? a ^ ((s == 2'h0) ? 2'h3 : ((s == 2'h1) ? 2'h2 : 2'h0)) : a;
        w = cv ? 32'hDDCCBBAA : 32'hAABBCCDD;
        if (d)
            i_dma.put(1'h1, e, p, c, s, a, 32'hAABBCCDD);
        else
            i_cpu.put(1'h1, e, p, c, s, a, 32'hAABBCCDD);
        @(posedge core_clk);
        #1;
        check(32'(d ? dma_convert : per_convert), 32'(cv));
        check(32'(d ? dma_addr_lo_out : per_addr_lo_out), 32'(ea));
        check(d ? dma_wdata_out : per_wdata_out, w);
        check(d ? dma_rdata_out : per_rdata_out, ~w);
    endtask
    task automatic t_little;
        start(1'h1, 1'h0, 1'h0, 1'h0);
        for (int i = 0; i < 4; i++) begin
            acc(1'h0, 1'h1, 1'h0, 2'(i), 2'h2, 2'h0, chip_select_area_config[i]);
        end
        acc(1'h0, 1'h0, 1'h0, 2'h1, 2'h0, 2'h1, 1'h0);
        acc(1'h1, 1'h1, 1'h0, 2'h1, 2'h0, 2'h1, 1'h1);
        acc(1'h1, 1'h0, 1'h1, 2'h1, 2'h1, 2'h0, 1'h0);
        $display("test little done");
    endtask
    task automatic t_big;
        @(posedge core_clk);
        chip_select_area_config <= 4'hD;
        start(1'h1, 1'h1, 1'h1, 1'h0);
        for (int i = 0; i < 4; i++) begin
            acc(1'h0, 1'h1, 1'h0, 2'(i), 2'h0, 2'(i), chip_select_area_config[i]);
        end
        acc(1'h0, 1'h0, 1'h0, 2'h0, 2'h1, 2'h0, 1'h1);
        acc(1'h1, 1'h0, 1'h1, 2'h0, 2'h2, 2'h0, 1'h1);
        acc(1'h1, 1'h0, 1'h0, 2'h0, 2'h2, 2'h0, 1'h0);
        acc(1'h1, 1'h1, 1'h0, 2'h1, 2'h1, 2'h2, 1'h0);
        @(posedge core_clk);
        dma_channel_config <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        check(32'(dma_order_mismatch), 32'h1);
        $display("test big done");
    endtask
    task automatic t_boot;
        start(1'h0, 1'h1, 1'h0, 1'h1);
        acc(1'h0, 1'h0, 1'h0, 2'h0, 2'h0, 2'h2, 1'h0);
        acc(1'h0, 1'h1, 1'h0, 2'h0, 2'h2, 2'h0, 1'h1);
        acc(1'h1, 1'h0, 1'h1, 2'h0, 2'h2, 2'h0, 1'h0);
        $display("test boot done");
    endtask
    initial begin
        t_little;
        t_big;
        t_boot;
        summarize;
    end
    initial begin
        #20000;
        failures++;
        summarize;
    end
endmodule
